// File: src/crnv_regs.vh
/*
  Offsets, field positions, reset values and keys of the coefficient,
  identity and memory access registers.
  Assumes it is included by its bare name from the design files.
*/
`ifndef CRNV_REGS_VH
`define CRNV_REGS_VH

// Register offsets
`define CRNV_OFF_SLOPE      8'h0E
`define CRNV_OFF_CURVE      8'h0F
`define CRNV_OFF_QUAD       8'h10
`define CRNV_OFF_TRZERO     8'h11
`define CRNV_OFF_TRONE      8'h12
`define CRNV_OFF_MAKER      8'h1E
`define CRNV_OFF_PARTREV    8'h1F
`define CRNV_OFF_MEMCTL     8'h2A

// Reset values
`define CRNV_RST_SLOPE      16'hFF71
`define CRNV_RST_CURVE      16'h0553
`define CRNV_RST_QUAD       16'h0000
`define CRNV_RST_TRZERO     16'h0034
`define CRNV_RST_TRONE      16'h0000
`define CRNV_RST_MEMCTL     16'h0000

// Writable bit masks; the quadratic gain keeps bits 3..0 at zero
`define CRNV_MSK_FULL       16'hFFFF
`define CRNV_MSK_QUAD       16'hFFF0

// Memory access register fields
`define CRNV_KEY            8'h6A
`define CRNV_KEY_HI         15
`define CRNV_KEY_LO         8
`define CRNV_CNT_HI         15
`define CRNV_CNT_LO         13
`define CRNV_CRPT_BIT       12
`define CRNV_SEL_HI         7
`define CRNV_SEL_LO         3
`define CRNV_GLOAD_BIT      2
`define CRNV_STORE_BIT      1
`define CRNV_SLOAD_BIT      0

// Endurance of one nonvolatile location
`define CRNV_MAX_PROGRAMS   4'h8
`define CRNV_CNT_SHOWN_MAX  3'h7

// Identity fields
`define CRNV_PART_HI        15
`define CRNV_PART_LO        4
`define CRNV_REV_HI         3
`define CRNV_REV_LO         0

`endif

// File: src/crnv_core.v
/*
  Coefficient register file with read-only identity registers and a
  memory access register that stores coefficients to, and reloads them
  from, a limited-endurance nonvolatile image.
  Assumes the two-wire serial front end turns bus transactions into
  single-cycle read and write strobes on i_ref_clk, and that the status
  register's corrupt flag comes from logic on the same clock.
  The image inside stands for the nonvolatile array; the o_nvm_ outputs
  only tell the physical array what to program, and the word and
  address hold after the pulse until the next accepted store.
*/
`timescale 1ns/100ps
`include "crnv_regs.vh"

module crnv_core #(
  parameter [15:0] MAKER_CODE = 16'hA5C3, // Value is arbitrary
  parameter [11:0] PART_CODE  = 12'h3B1,  // Value is arbitrary
  parameter [3:0]  REV_CODE   = 4'h2      // Value is arbitrary
) (
  input  wire        i_ref_clk,
  input  wire        i_reset,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [7:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_status_mem_corrupt,
  output wire [15:0] o_rdata,
  output wire        o_rd_valid,
  output wire [15:0] o_coef_second_order_slope,
  output wire [15:0] o_coef_second_order_curve,
  output wire [15:0] o_coef_quadratic_gain,
  output wire [15:0] o_coef_transient_zero,
  output wire [15:0] o_coef_transient_one,
  output wire        o_nvm_store,
  output wire [4:0]  o_nvm_addr,
  output wire [15:0] o_nvm_wdata
);

  localparam integer NLOC = 5;

  // Per-location tables, entry 0 is the slope coefficient
  localparam [8*NLOC-1:0] LOC_OFF = {
    `CRNV_OFF_TRONE,
    `CRNV_OFF_TRZERO,
    `CRNV_OFF_QUAD,
    `CRNV_OFF_CURVE,
    `CRNV_OFF_SLOPE
  };

  localparam [16*NLOC-1:0] LOC_RST = {
    `CRNV_RST_TRONE,
    `CRNV_RST_TRZERO,
    `CRNV_RST_QUAD,
    `CRNV_RST_CURVE,
    `CRNV_RST_SLOPE
  };

  localparam [16*NLOC-1:0] LOC_MSK = {
    `CRNV_MSK_FULL,
    `CRNV_MSK_FULL,
    `CRNV_MSK_QUAD,
    `CRNV_MSK_FULL,
    `CRNV_MSK_FULL
  };

  wire                  memctl_wr;
  wire                  key_ok;
  wire [4:0]            sel_field;
  wire                  op_gload;
  wire                  op_store;
  wire                  op_sload;
  wire [16*NLOC-1:0]    coef_flat;
  wire [4*NLOC-1:0]     cnt_flat;
  wire [NLOC-1:0]       sel_hit;
  wire [NLOC-1:0]       store_ok;
  reg  [4:0]            sel_q;
  reg  [3:0]            sel_cnt;
  reg  [15:0]           store_word;
  reg                   store_any;
  reg  [15:0]           rd_mux;
  reg  [2:0]            cnt_shown;
  reg  [4:0]            sel_d;
  reg  [15:0]           memctl_word;
  reg  [15:0]           rdata_q;
  reg  [15:0]           rdata_d;
  reg                   rd_valid_q;
  reg                   nvm_store_q;
  reg  [4:0]            nvm_addr_q;
  reg  [4:0]            nvm_addr_d;
  reg  [15:0]           nvm_wdata_q;
  reg  [15:0]           nvm_wdata_d;
  integer               k;
  integer               m;

  // Memory access writes are commands, only the select is kept
  assign memctl_wr = i_wr_en && (i_addr == `CRNV_OFF_MEMCTL);
  // Without the key nothing is stored or loaded
  assign key_ok    = memctl_wr &&
                     (i_wdata[`CRNV_KEY_HI:`CRNV_KEY_LO] == `CRNV_KEY);
  assign sel_field = i_wdata[`CRNV_SEL_HI:`CRNV_SEL_LO];

  // General load outranks a store, a store outranks a single load
  assign op_gload = key_ok && i_wdata[`CRNV_GLOAD_BIT];
  assign op_store = key_ok && i_wdata[`CRNV_STORE_BIT] &&
                    !i_wdata[`CRNV_GLOAD_BIT];
  assign op_sload = key_ok && i_wdata[`CRNV_SLOAD_BIT] &&
                    !i_wdata[`CRNV_GLOAD_BIT] &&
                    !i_wdata[`CRNV_STORE_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NLOC; gi = gi + 1) begin : gen_loc
      reg  [15:0] coef_q;
      reg  [15:0] coef_d;
      reg  [15:0] image_q;
      reg  [15:0] image_d;
      reg  [3:0]  cnt_q;
      reg  [3:0]  cnt_d;
      wire        wr_hit;

      // Identity offsets match no location, so writes to them vanish
      assign wr_hit = i_wr_en && (i_addr == LOC_OFF[8*gi +: 8]);
      assign sel_hit[gi] = (sel_field == LOC_OFF[8*gi +: 5]);
      // A worn-out location silently drops the store
      assign store_ok[gi] = op_store && sel_hit[gi] &&
                            (cnt_q < `CRNV_MAX_PROGRAMS);

      // A load and a host write never meet: one address per cycle
      always @* begin
        if (op_gload) begin
          coef_d = image_q;
        end else if (op_sload && sel_hit[gi]) begin
          coef_d = image_q;
        end else if (wr_hit) begin
          coef_d = i_wdata & LOC_MSK[16*gi +: 16];
        end else begin
          coef_d = coef_q;
        end
      end

      // reset values and masked host writes
      always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
          coef_q <= LOC_RST[16*gi +: 16];
        end else begin
          coef_q <= coef_d;
        end
      end

      // Four count bits so the ninth store can be told from the eighth
      always @* begin
        if (store_ok[gi]) begin
          image_d = coef_q;
          cnt_d   = cnt_q + 4'h1;
        end else begin
          image_d = image_q;
          cnt_d   = cnt_q;
        end
      end

      // The image starts at the reset coefficients so an early load
      // before any store returns the defaults, not garbage
      always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
          image_q <= LOC_RST[16*gi +: 16];
          cnt_q   <= 4'h0;
        end else begin
          image_q <= image_d;
          cnt_q   <= cnt_d;
        end
      end

      assign coef_flat[16*gi +: 16] = coef_q;
      assign cnt_flat[4*gi +: 4]    = cnt_q;
    end
  endgenerate

  assign o_coef_second_order_slope = coef_flat[15:0];
  assign o_coef_second_order_curve = coef_flat[31:16];
  assign o_coef_quadratic_gain     = coef_flat[47:32];
  assign o_coef_transient_zero     = coef_flat[63:48];
  assign o_coef_transient_one      = coef_flat[79:64];

  // Selected location is remembered from the last keyed write
  always @* begin
    if (key_ok) begin
      sel_d = sel_field;
    end else begin
      sel_d = sel_q;
    end
  end

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_q <= 5'h00;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Word and flag for the physical array write
  always @* begin
    store_word = 16'h0000;
    store_any  = 1'b0;
    for (k = 0; k < NLOC; k = k + 1) begin
      if (store_ok[k]) begin
        store_word = coef_flat[16*k +: 16];
        store_any  = 1'b1;
      end
    end
  end

  // Address and word stay put after the pulse for a slow array
  always @* begin
    if (store_any) begin
      nvm_addr_d  = sel_field;
      nvm_wdata_d = store_word;
    end else begin
      nvm_addr_d  = nvm_addr_q;
      nvm_wdata_d = nvm_wdata_q;
    end
  end

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      nvm_store_q <= 1'h0;
      nvm_addr_q  <= 5'h00;
      nvm_wdata_q <= 16'h0000;
    end else begin
      nvm_store_q <= store_any;
      nvm_addr_q  <= nvm_addr_d;
      nvm_wdata_q <= nvm_wdata_d;
    end
  end

  assign o_nvm_store = nvm_store_q;
  assign o_nvm_addr  = nvm_addr_q;
  assign o_nvm_wdata = nvm_wdata_q;

  // Count of the selected location; 0 for offsets with no location
  always @* begin
    sel_cnt = 4'h0;
    for (m = 0; m < NLOC; m = m + 1) begin
      if (sel_q == LOC_OFF[8*m +: 5]) begin
        sel_cnt = cnt_flat[4*m +: 4];
      end
    end
  end

  // Three bits cannot show eight, so a worn-out location reads seven
  always @* begin
    if (sel_cnt >= `CRNV_MAX_PROGRAMS) begin
      cnt_shown = `CRNV_CNT_SHOWN_MAX;
    end else begin
      cnt_shown = sel_cnt[2:0];
    end
  end

  // Unused bits and the write-only command bits read back as zero
  always @* begin
    memctl_word = `CRNV_RST_MEMCTL;
    memctl_word[`CRNV_CNT_HI:`CRNV_CNT_LO] = cnt_shown;
    memctl_word[`CRNV_CRPT_BIT] = i_status_mem_corrupt;
    memctl_word[`CRNV_SEL_HI:`CRNV_SEL_LO] = sel_q;
  end

  // Unmapped offsets read zero so a stray read leaks nothing
  always @* begin
    case (i_addr)
      `CRNV_OFF_SLOPE: begin
        rd_mux = coef_flat[15:0];
      end
      `CRNV_OFF_CURVE: begin
        rd_mux = coef_flat[31:16];
      end
      `CRNV_OFF_QUAD: begin
        rd_mux = coef_flat[47:32];
      end
      `CRNV_OFF_TRZERO: begin
        rd_mux = coef_flat[63:48];
      end
      `CRNV_OFF_TRONE: begin
        rd_mux = coef_flat[79:64];
      end
      `CRNV_OFF_MAKER: begin
        rd_mux = MAKER_CODE;
      end
      `CRNV_OFF_PARTREV: begin
        rd_mux = 16'h0000;
        rd_mux[`CRNV_PART_HI:`CRNV_PART_LO] = PART_CODE;
        rd_mux[`CRNV_REV_HI:`CRNV_REV_LO]   = REV_CODE;
      end
      `CRNV_OFF_MEMCTL: begin
        rd_mux = memctl_word;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  // Read word holds until the next read so a slow front end can ship it
  always @* begin
    if (i_rd_en) begin
      rdata_d = rd_mux;
    end else begin
      rdata_d = rdata_q;
    end
  end

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q    <= 16'h0000;
      rd_valid_q <= 1'h0;
    end else begin
      rdata_q    <= rdata_d;
      rd_valid_q <= i_rd_en;
    end
  end

  assign o_rdata    = rdata_q;
  assign o_rd_valid = rd_valid_q;

endmodule

// File: verification/crnv_core_asserts.sv
/* Checker for crnv_core register port and store pulses.
   Assumes one clock and the asynchronous active-high reset. */
`timescale 1ns/100ps
module crnv_core_asserts #(
  parameter [15:0] MAKER_CODE = 16'hA5C3,
  parameter [11:0] PART_CODE  = 12'h3B1,
  parameter [3:0]  REV_CODE   = 4'h2
) (
  input wire        i_ref_clk,
  input wire        i_reset,
  input wire        i_wr_en,
  input wire        i_rd_en,
  input wire [7:0]  i_addr,
  input wire [15:0] i_wdata,
  input wire        i_status_mem_corrupt,
  input wire [15:0] o_rdata,
  input wire        o_rd_valid,
  input wire [15:0] o_coef_second_order_slope,
  input wire [15:0] o_coef_second_order_curve,
  input wire [15:0] o_coef_quadratic_gain,
  input wire [15:0] o_coef_transient_zero,
  input wire [15:0] o_coef_transient_one,
  input wire        o_nvm_store,
  input wire [4:0]  o_nvm_addr,
  input wire [15:0] o_nvm_wdata
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_rd(a);
    i_rd_en && i_addr == a;
  endsequence
  sequence s_ctl_wr;
    i_wr_en && i_addr == 8'h2A;
  endsequence
  chk_reset_vals: assert property (
    $fell(i_reset) |-> o_coef_second_order_slope == 16'hFF71
    && o_coef_second_order_curve == 16'h0553
    && o_coef_quadratic_gain == 16'h0000
    && o_coef_transient_zero == 16'h0034
    && o_coef_transient_one == 16'h0000) else $error("bad reset value");
  chk_slope_write: assert property (
    i_wr_en && i_addr == 8'h0E |=>
    o_coef_second_order_slope == $past(i_wdata)) else $error("slope lost");
  chk_quad_low: assert property (
    o_coef_quadratic_gain[3:0] == 4'h0) else $error("gain low bits set");
  chk_maker_read: assert property (
    s_rd(8'h1E) |=> o_rd_valid && o_rdata == MAKER_CODE)
    else $error("maker code wrong");
  chk_part_read: assert property (
    s_rd(8'h1F) |=> o_rdata == {PART_CODE, REV_CODE})
    else $error("part code wrong");
  chk_ctl_read: assert property (
    s_rd(8'h2A) |=> o_rdata[12] == $past(i_status_mem_corrupt)
    && o_rdata[11:8] == 4'h0 && o_rdata[2:0] == 3'h0)
    else $error("control read wrong");
  chk_no_key: assert property (
    (s_ctl_wr ##0 i_wdata[15:8] != 8'h6A) |=> !o_nvm_store)
    else $error("store without key");
  chk_store_cause: assert property (
    o_nvm_store |-> $past(i_wr_en && i_addr == 8'h2A
    && i_wdata[15:8] == 8'h6A && i_wdata[2:1] == 2'b01)
    && o_nvm_addr == $past(i_wdata[7:3])) else $error("stray store");
  chk_store_word: assert property (
    o_nvm_store && o_nvm_addr == 5'h0E |->
    o_nvm_wdata == $past(o_coef_second_order_slope))
    else $error("stored word wrong");
endmodule
bind crnv_core crnv_core_asserts #(.MAKER_CODE(MAKER_CODE),
  .PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) u_chk (.*);

// File: verification/crnv_host.sv
/* Host model on the register port, one strobe per access.
   Assumes the bench owns the clock and reads the result queue. */
`timescale 1ns/100ps
module crnv_host (
  input  wire        i_clk,
  output reg         o_wr_en,
  output reg         o_rd_en,
  output reg  [7:0]  o_addr,
  output reg  [15:0] o_wdata
);
  logic [15:0] exp_q[$];
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_wdata = ~d; // Old data must not look valid
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
  endtask
endmodule

// File: verification/crnv_core_tb_top.sv
/* Self-checking bench for crnv_core: host model drives, a monitor
   checks reads and counts stores. Assumes default identity codes. */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module crnv_core_tb_top;
  logic        clk;
  logic        rst;
  logic        crpt;
  wire         wr_en, rd_en, rd_valid, nvm_st;
  wire  [7:0]  addr;
  wire  [4:0]  nvm_a;
  wire  [15:0] wdata, rdata, nvm_w;
  wire  [79:0] coefs;
  int          fails, comparisons, stores;
  logic [15:0] d, e;
  logic [20:0] s, st_q[$];
  logic [7:0]  ra [8] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h1E,
                          8'h1F, 8'h2A};
  logic [15:0] rv [8] = '{16'hFF71, 16'h0553, 16'h0000, 16'h0034,
                          16'h0000, 16'hA5C3, 16'h3B12, 16'h0000};
  crnv_host host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata));
  crnv_core DUT (.i_ref_clk(clk), .i_reset(rst), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .i_status_mem_corrupt(crpt), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_coef_second_order_slope(coefs[79:64]),
    .o_coef_second_order_curve(coefs[63:48]),
    .o_coef_quadratic_gain(coefs[47:32]),
    .o_coef_transient_zero(coefs[31:16]),
    .o_coef_transient_one(coefs[15:0]), .o_nvm_store(nvm_st),
    .o_nvm_addr(nvm_a), .o_nvm_wdata(nvm_w));
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Falling edge sampling keeps clear of the launching edge
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      e = host.exp_q.pop_front();
      `CHK(rdata, e)
    end
    if (nvm_st === 1'b1) begin
      stores++;
      s = st_q.pop_front();
      `CHK({nvm_a, nvm_w}, s)
    end
  end
  initial begin
    #50000;
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(32'h94A466C9));
    rst = 1'b1;
    crpt = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) host.rd(ra[i], rv[i]);
    for (int i = 0; i < 6; i++) begin
      d = 16'($urandom);
      host.wr(ra[i], d);
      host.rd(ra[i], i == 2 ? d & 16'hFFF0 : i == 5 ? rv[5] : d);
    end
    d = 16'($urandom);
    host.wr(8'h0E, d);
    st_q.push_back({5'h0E, d});
    host.wr(8'h2A, 16'h6A72);
    host.rd(8'h2A, 16'h2070);
    host.wr(8'h2A, 16'h5A7A);
    host.rd(8'h2A, 16'h2070);
    host.wr(8'h0E, ~d);
    host.wr(8'h2A, 16'h6A71);
    host.rd(8'h0E, d);
    host.wr(8'h0E, ~d);
    host.wr(8'h0F, ~d);
    host.wr(8'h2A, 16'h6A04);
    host.rd(8'h0E, d);
    host.rd(8'h0F, 16'h0553);
    `CHK(coefs, {d, 64'h0553_0000_0034_0000})
    // Ninth store to one place must be dropped
    for (int i = 0; i < 9; i++) begin
      if (i < 8) st_q.push_back({5'h0F, 16'h0553});
      host.wr(8'h2A, 16'h6A7A);
    end
    crpt = 1'b1;
    host.rd(8'h2A, 16'hF078);
    repeat (3) @(negedge clk);
    `CHK(stores, 9)
    `CHK(host.exp_q.size(), 0)
    `CHK(st_q.size(), 0)
    final_report();
  end
endmodule
